/* File: core/frame_cfg_pkg.sv */
// Shared constants for the frame configuration register bank.
// Assumes a 32-bit APB slave with one aligned word per 8-bit register.
package frame_cfg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SPARE_A      = 8'h1A;
	localparam logic [7:0] IDX_SPARE_B      = 8'h1B;
	localparam logic [7:0] IDX_TX_WAIT      = 8'h1C;
	localparam logic [7:0] IDX_PARITY       = 8'h1D;
	localparam logic [7:0] IDX_SPARE_C      = 8'h1E;
	localparam logic [7:0] IDX_BAUD         = 8'h1F;
	localparam logic [7:0] IDX_SPARE_D      = 8'h20;
	localparam logic [7:0] IDX_CRC_HIGH     = 8'h21;
	localparam logic [7:0] IDX_CRC_LOW      = 8'h22;
	localparam logic [7:0] IDX_SPARE_E      = 8'h23;

	// Reset contents
	localparam logic [7:0] RST_SPARE_A      = 8'h00;
	localparam logic [7:0] RST_SPARE_B      = 8'h00;
	localparam logic [7:0] RST_TX_WAIT      = 8'h62;
	localparam logic [7:0] RST_PARITY       = 8'h00;
	localparam logic [7:0] RST_SPARE_C      = 8'h00;
	localparam logic [7:0] RST_BAUD         = 8'hEB;
	localparam logic [7:0] RST_SPARE_D      = 8'h00;
	localparam logic [7:0] RST_CRC_BYTE     = 8'hFF;
	localparam logic [7:0] RST_SPARE_E      = 8'h88;

	// Field layout
	localparam int         WAIT_FIELD_W     = 2;
	localparam logic [7:0] TX_WAIT_FIXED    = 8'h60;
	localparam int         PARITY_BYPASS_BIT = 4;
	localparam int         COARSE_LSB       = 5;
	localparam int         COARSE_W         = 3;
	localparam int         FINE_LSB         = 0;
	localparam int         FINE_W           = 5;

	// Response wait: fixed bit periods added to the field
	localparam int         WAIT_CNT_W       = 4;
	localparam logic [3:0] RESP_WAIT_BASE   = 4'h7;

	// Bus geometry
	localparam int         ADDR_W           = 8;
	localparam int         DATA_W           = 32;

	// Byte address of a register index
	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		return {idx[5:0], 2'h0};
	endfunction : byte_addr

endpackage : frame_cfg_pkg

/* File: core/frame_cfg_regs.sv */
// Frame configuration register bank: response wait, parity bypass,
// host baud factors and the read-only checksum result pair.
// Assumes an APB master on mclk_in and a checksum engine on the same clock.
`timescale 1ns/10ps

// Operation
// - The two-bit response wait field lengthens the response time by seven bit periods plus the field value.
// - With the parity bypass bit set, no parity is generated on sent frames and none is checked on received ones.
// - With parity bypass set, the received bit in the parity position is passed on as a data bit.
// - The parity control register resets to zero, so parity is generated and checked after reset.
// - The host baud register holds a coarse factor in bits 7 to 5 and a fine factor in bits 4 to 0.
// - The host baud register resets to EBh.
// - The checksum result is two read-only bytes, high byte at 21h and low byte at 22h.
// - Both checksum result bytes reset to FFh.
module frame_cfg_regs (
	input  wire logic                           mclk_in,
	input  wire logic                           rstn_in,
	input  wire logic                           psel_in,
	input  wire logic                           penable_in,
	input  wire logic                           pwrite_in,
	input  wire logic [frame_cfg_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic [frame_cfg_pkg::DATA_W-1:0] pwdata_in,
	input  wire logic [3:0]                     pstrb_in,
	output logic      [frame_cfg_pkg::DATA_W-1:0] prdata_out,
	output logic                                pready_out,
	output logic                                pslverr_out,
	input  wire logic                           tx_char_valid_in,
	input  wire logic [7:0]                     tx_char_in,
	input  wire logic                           tx_frame_end_in,
	input  wire logic                           bit_tick_in,
	input  wire logic                           rx_char_valid_in,
	input  wire logic [7:0]                     rx_char_in,
	input  wire logic                           rx_par_bit_in,
	input  wire logic                           crc_load_in,
	input  wire logic [15:0]                    crc_value_in,
	output logic                                tx_parity_valid_out,
	output logic                                tx_parity_out,
	output logic                                rx_data_valid_out,
	output logic [7:0]                          rx_data_out,
	output logic                                rx_extra_valid_out,
	output logic                                rx_extra_bit_out,
	output logic                                rx_parity_err_out,
	output logic [frame_cfg_pkg::WAIT_CNT_W-1:0] response_wait_bits_out,
	output logic                                response_wait_busy_out,
	output logic                                response_wait_done_out,
	output logic [frame_cfg_pkg::COARSE_W-1:0]  baud_coarse_factor_out,
	output logic [frame_cfg_pkg::FINE_W-1:0]    baud_fine_factor_out
);
	import frame_cfg_pkg::*;

	// Reset release through two flops; assertion stays asynchronous
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Software-visible state
	logic [WAIT_FIELD_W-1:0] response_wait_extension_reg;
	logic                    parity_bypass_reg;
	logic [7:0]              host_baud_config_reg;
	logic [7:0]              checksum_high_value_reg;
	logic [7:0]              checksum_low_value_reg;

	// APB answer flops
	logic                    pready_reg;
	logic [DATA_W-1:0]       prdata_reg;
	logic                    pslverr_reg;

	// Bus phase decode
	wire        acc_first = psel_in & penable_in & ~pready_reg;
	wire        apb_done  = psel_in & penable_in & pready_reg;
	wire [7:0]  reg_idx   = {2'h0, paddr_in[7:2]};
	wire        aligned   = (paddr_in[1:0] == 2'h0);
	wire        map_hit   = aligned & (reg_idx >= IDX_SPARE_A) & (reg_idx <= IDX_SPARE_E);
	wire        wr_lane   = apb_done & pwrite_in & pstrb_in[0] & map_hit;

	// Write strobes per writable register; reserved and checksum slots have none
	wire        wr_tx_wait = wr_lane & (reg_idx == IDX_TX_WAIT);
	wire        wr_parity  = wr_lane & (reg_idx == IDX_PARITY);
	wire        wr_baud    = wr_lane & (reg_idx == IDX_BAUD);

	// Read view of the wait and parity registers; unused wait bits read as the fixed pattern, unused parity bits as zero
	wire [7:0]  tx_wait_view = TX_WAIT_FIXED | {6'h00, response_wait_extension_reg};
	wire [7:0]  parity_view  = {3'h0, parity_bypass_reg, 4'h0};

	// Read selection, reserved slots return their fixed contents
	wire [7:0]  rd_byte =
		(reg_idx == IDX_SPARE_A)  ? RST_SPARE_A :
		(reg_idx == IDX_SPARE_B)  ? RST_SPARE_B :
		(reg_idx == IDX_TX_WAIT)  ? tx_wait_view :
		(reg_idx == IDX_PARITY)   ? parity_view :
		(reg_idx == IDX_SPARE_C)  ? RST_SPARE_C :
		(reg_idx == IDX_BAUD)     ? host_baud_config_reg :
		(reg_idx == IDX_SPARE_D)  ? RST_SPARE_D :
		(reg_idx == IDX_CRC_HIGH) ? checksum_high_value_reg :
		(reg_idx == IDX_CRC_LOW)  ? checksum_low_value_reg :
		RST_SPARE_E;

	wire [DATA_W-1:0] rd_word = map_hit ? {24'h000000, rd_byte} : 32'h00000000;

	// One wait state so every answer leaves a flop
	always_ff @(posedge mclk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= acc_first;
			prdata_reg  <= acc_first ? (pwrite_in ? 32'h00000000 : rd_word) : prdata_reg;
			pslverr_reg <= acc_first & ~map_hit;
		end
	end

	// Configuration registers, written only at the completing edge
	always_ff @(posedge mclk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			response_wait_extension_reg <= RST_TX_WAIT[WAIT_FIELD_W-1:0];
			parity_bypass_reg           <= RST_PARITY[PARITY_BYPASS_BIT];
			host_baud_config_reg        <= RST_BAUD;
		end else begin
			if (wr_tx_wait)
				response_wait_extension_reg <= pwdata_in[WAIT_FIELD_W-1:0];
			if (wr_parity)
				parity_bypass_reg <= pwdata_in[PARITY_BYPASS_BIT];
			if (wr_baud)
				host_baud_config_reg <= pwdata_in[7:0];
		end
	end

	// Checksum result pair, loaded only by the engine, never by the bus
	always_ff @(posedge mclk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			checksum_high_value_reg <= RST_CRC_BYTE;
			checksum_low_value_reg  <= RST_CRC_BYTE;
		end else if (crc_load_in) begin
			checksum_high_value_reg <= crc_value_in[15:8];
			checksum_low_value_reg  <= crc_value_in[7:0];
		end
	end

	// Total wait, base added in front of the timer so it sees one figure
	wire [WAIT_CNT_W-1:0] wait_total = RESP_WAIT_BASE + {2'h0, response_wait_extension_reg};

	// Baud factors and wait length leave as flops
	always_ff @(posedge mclk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			response_wait_bits_out <= 4'h0;
			baud_coarse_factor_out <= 3'h0;
			baud_fine_factor_out   <= 5'h00;
		end else begin
			response_wait_bits_out <= wait_total;
			baud_coarse_factor_out <= host_baud_config_reg[COARSE_LSB +: COARSE_W];
			baud_fine_factor_out   <= host_baud_config_reg[FINE_LSB +: FINE_W];
		end
	end

	assign prdata_out  = prdata_reg;
	assign pready_out  = pready_reg;
	assign pslverr_out = pslverr_reg;

	// Response wait counter, started by the end of each sent frame
	response_wait_timer u_wait (
		.mclk_in      (mclk_in),
		.rstn_in      (rst_sync_reg),
		.start_in     (tx_frame_end_in),
		.bit_tick_in  (bit_tick_in),
		.wait_bits_in (wait_total),
		.busy_out     (response_wait_busy_out),
		.done_out     (response_wait_done_out)
	);

	// Parity generation and checking, steered by the bypass bit
	parity_frame_unit u_parity (
		.mclk_in             (mclk_in),
		.rstn_in             (rst_sync_reg),
		.bypass_in           (parity_bypass_reg),
		.tx_char_valid_in    (tx_char_valid_in),
		.tx_char_in          (tx_char_in),
		.rx_char_valid_in    (rx_char_valid_in),
		.rx_char_in          (rx_char_in),
		.rx_par_bit_in       (rx_par_bit_in),
		.tx_parity_valid_out (tx_parity_valid_out),
		.tx_parity_out       (tx_parity_out),
		.rx_data_valid_out   (rx_data_valid_out),
		.rx_data_out         (rx_data_out),
		.rx_extra_valid_out  (rx_extra_valid_out),
		.rx_extra_bit_out    (rx_extra_bit_out),
		.rx_parity_err_out   (rx_parity_err_out)
	);

	// Checks next to the bank

	a_wait_from_write: assert property (@(posedge mclk_in) disable iff (!rst_sync_reg)
		wr_tx_wait |=> ##1 (response_wait_bits_out == RESP_WAIT_BASE + {2'h0, $past(pwdata_in[1:0], 2)}))
		else $error("wait length is not seven plus the written field");

	a_reset_values: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$rose(rst_sync_reg) |-> !parity_bypass_reg && (host_baud_config_reg == RST_BAUD)
			&& (checksum_high_value_reg == RST_CRC_BYTE) && (checksum_low_value_reg == RST_CRC_BYTE))
		else $error("register bank left reset with wrong contents");

	a_baud_split: assert property (@(posedge mclk_in) disable iff (!rst_sync_reg)
		wr_baud |=> ##1 (baud_coarse_factor_out == $past(pwdata_in[7:5], 2))
			&& (baud_fine_factor_out == $past(pwdata_in[4:0], 2)))
		else $error("baud factors not split at bit five");

	a_checksum_read: assert property (@(posedge mclk_in) disable iff (!rst_sync_reg)
		(acc_first && !pwrite_in && (paddr_in == byte_addr(IDX_CRC_HIGH))) |=>
			pready_out && (prdata_out == {24'h000000, checksum_high_value_reg}))
		else $error("high checksum byte not returned at its address");

	a_checksum_ro: assert property (@(posedge mclk_in) disable iff (!rst_sync_reg)
		(apb_done && pwrite_in && !crc_load_in && (reg_idx == IDX_CRC_LOW)) |=>
			$stable(checksum_low_value_reg))
		else $error("bus write altered a read-only checksum byte");

	a_spare_fixed: assert property (@(posedge mclk_in) disable iff (!rst_sync_reg)
		(acc_first && !pwrite_in && (paddr_in == byte_addr(IDX_SPARE_E))) |=>
			(prdata_out == {24'h000000, RST_SPARE_E}) && !pslverr_out)
		else $error("reserved slot did not return its fixed contents");

	a_unmapped_error: assert property (@(posedge mclk_in) disable iff (!rst_sync_reg)
		(acc_first && !map_hit) |=> pready_out && pslverr_out && (prdata_out == 32'h00000000))
		else $error("unmapped access not answered with an error");

endmodule : frame_cfg_regs

/* File: core/parity_frame_unit.sv */
// Odd parity generation for sent characters and checking for received ones.
// Assumes character strobes come from logic on the same clock.
`timescale 1ns/10ps
module parity_frame_unit (
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	input  wire logic       bypass_in,
	input  wire logic       tx_char_valid_in,
	input  wire logic [7:0] tx_char_in,
	input  wire logic       rx_char_valid_in,
	input  wire logic [7:0] rx_char_in,
	input  wire logic       rx_par_bit_in,
	output logic            tx_parity_valid_out,
	output logic            tx_parity_out,
	output logic            rx_data_valid_out,
	output logic [7:0]      rx_data_out,
	output logic            rx_extra_valid_out,
	output logic            rx_extra_bit_out,
	output logic            rx_parity_err_out
);
	import frame_cfg_pkg::*;

	// Odd parity bit for one character
	function automatic logic odd_parity(input logic [7:0] d);
		return ~(^d);
	endfunction : odd_parity

	wire tx_par_on  = tx_char_valid_in & ~bypass_in;
	wire rx_check   = rx_char_valid_in & ~bypass_in;
	wire rx_as_data = rx_char_valid_in & bypass_in;
	wire rx_bad     = rx_check & (rx_par_bit_in != odd_parity(rx_char_in));

	// Parity stage, one cycle behind the character strobe
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_parity_valid_out <= 1'b0;
			tx_parity_out       <= 1'b0;
			rx_data_valid_out   <= 1'b0;
			rx_data_out         <= 8'h00;
			rx_extra_valid_out  <= 1'b0;
			rx_extra_bit_out    <= 1'b0;
			rx_parity_err_out   <= 1'b0;
		end else begin
			tx_parity_valid_out <= tx_par_on;
			tx_parity_out       <= tx_par_on & odd_parity(tx_char_in);
			rx_data_valid_out   <= rx_char_valid_in;
			rx_data_out         <= rx_char_valid_in ? rx_char_in : rx_data_out;
			rx_extra_valid_out  <= rx_as_data;
			rx_extra_bit_out    <= rx_as_data & rx_par_bit_in;
			rx_parity_err_out   <= rx_bad;
		end
	end

	a_tx_parity_off: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		tx_char_valid_in |=> (tx_parity_valid_out == !$past(bypass_in)))
		else $error("parity generation does not follow the bypass bit");

	a_rx_check_off: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(rx_char_valid_in && bypass_in) |=> !rx_parity_err_out)
		else $error("parity error raised while checking is bypassed");

	a_rx_parity_data: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(rx_char_valid_in && bypass_in) |=> rx_extra_valid_out && rx_data_valid_out
			&& (rx_extra_bit_out == $past(rx_par_bit_in)))
		else $error("received parity position not passed on as data");

endmodule : parity_frame_unit

/* File: core/response_wait_timer.sv */
// Counts the extended response wait in bit periods after a frame.
// Assumes bit_tick_in is a one-cycle pulse per bit period, same clock.
`timescale 1ns/10ps
module response_wait_timer (
	input  wire logic                               mclk_in,
	input  wire logic                               rstn_in,
	input  wire logic                               start_in,
	input  wire logic                               bit_tick_in,
	input  wire logic [frame_cfg_pkg::WAIT_CNT_W-1:0] wait_bits_in,
	output logic                                    busy_out,
	output logic                                    done_out
);
	import frame_cfg_pkg::*;

	logic [WAIT_CNT_W-1:0] cnt_reg;
	logic [WAIT_CNT_W-1:0] cnt_next;
	logic                  busy_next;
	logic                  done_next;
	wire                   last_tick = busy_out & bit_tick_in & (cnt_reg == 4'h1);

	// Restart wins over a tick so a new frame always gets a full wait
	assign cnt_next  = start_in ? wait_bits_in :
	                   (busy_out & bit_tick_in) ? cnt_reg - 4'h1 : cnt_reg;
	assign busy_next = start_in ? (wait_bits_in != 4'h0) : (busy_out & ~last_tick);
	assign done_next = last_tick & ~start_in;

	// Counter state
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg  <= 4'h0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			busy_out <= busy_next;
			done_out <= done_next;
		end
	end

	a_wait_load_count: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		start_in |=> (cnt_reg == $past(wait_bits_in)) && busy_out)
		else $error("wait counter did not load the programmed length");

	a_wait_done_end: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		done_out |-> $past(busy_out) && $past(bit_tick_in) && ($past(cnt_reg) == 4'h1) && !busy_out)
		else $error("wait ended before its last bit period");

endmodule : response_wait_timer

/* File: testbench/test_contactless_frame_config_regs.sv */
// Self-checking bench for the frame configuration register bank.
// Assumes the bank answers APB with one wait state and checks its own rules in place.
`timescale 1ns/10ps
module test_contactless_frame_config_regs;
	import frame_cfg_pkg::*;

	logic               mclk_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic [ADDR_W-1:0]  paddr_in;
	logic [DATA_W-1:0]  pwdata_in, prdata_out;
	logic [3:0]         pstrb_in;
	logic               tx_char_valid_in, tx_frame_end_in, bit_tick_in, rx_char_valid_in, rx_par_bit_in;
	logic [7:0]         tx_char_in, rx_char_in, rx_data_out;
	logic               crc_load_in;
	logic [15:0]        crc_value_in;
	logic               tx_parity_valid_out, tx_parity_out, rx_data_valid_out, rx_extra_valid_out;
	logic               rx_extra_bit_out, rx_parity_err_out, response_wait_busy_out, response_wait_done_out;
	logic [WAIT_CNT_W-1:0] response_wait_bits_out;
	logic [COARSE_W-1:0]   baud_coarse_factor_out;
	logic [FINE_W-1:0]     baud_fine_factor_out;
	int                 failures, cmp_count;
	logic [7:0]         map_idx [10] = '{IDX_SPARE_A, IDX_SPARE_B, IDX_TX_WAIT, IDX_PARITY, IDX_SPARE_C,
		IDX_BAUD, IDX_SPARE_D, IDX_CRC_HIGH, IDX_CRC_LOW, IDX_SPARE_E};
	logic [7:0]         map_rst [10] = '{RST_SPARE_A, RST_SPARE_B, RST_TX_WAIT, RST_PARITY, RST_SPARE_C,
		RST_BAUD, RST_SPARE_D, RST_CRC_BYTE, RST_CRC_BYTE, RST_SPARE_E};

	frame_cfg_regs uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.tx_char_valid_in(tx_char_valid_in), .tx_char_in(tx_char_in), .tx_frame_end_in(tx_frame_end_in),
		.bit_tick_in(bit_tick_in), .rx_char_valid_in(rx_char_valid_in), .rx_char_in(rx_char_in),
		.rx_par_bit_in(rx_par_bit_in), .crc_load_in(crc_load_in), .crc_value_in(crc_value_in),
		.tx_parity_valid_out(tx_parity_valid_out), .tx_parity_out(tx_parity_out),
		.rx_data_valid_out(rx_data_valid_out), .rx_data_out(rx_data_out),
		.rx_extra_valid_out(rx_extra_valid_out), .rx_extra_bit_out(rx_extra_bit_out),
		.rx_parity_err_out(rx_parity_err_out), .response_wait_bits_out(response_wait_bits_out),
		.response_wait_busy_out(response_wait_busy_out), .response_wait_done_out(response_wait_done_out),
		.baud_coarse_factor_out(baud_coarse_factor_out), .baud_fine_factor_out(baud_fine_factor_out));

	// 50 MHz clock
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	// Expected values, worked out independently of the design
	function automatic logic [7:0] addr_of(input logic [7:0] idx);
		return {idx[5:0], 2'h0};
	endfunction : addr_of
	function automatic logic odd_par(input logic [7:0] c);
		return ~^c;
	endfunction : odd_par

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word
	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	// One APB transfer; request held until pready, a hang is ended by the watchdog
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, input logic [3:0] strb,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= addr;
		pwdata_in <= wd;
		pstrb_in <= strb;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		chk_word("pready wait", 32'd2, 32'(n));
	endtask : apb
	task automatic wr(input logic [7:0] addr, input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, addr, wd, strb, rd, err);
	endtask : wr
	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp, input logic experr);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, addr, 32'h0, 4'h0, rd, err);
		chk_word(what, exp, rd);
		chk_bit("pslverr", experr, err);
	endtask : rd_chk

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// Watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge mclk_in);
		failures++;
		stop_test();
	end

	// Main sequence
	initial begin
		logic [7:0]  v, c;
		logic        p, b;
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = '0;
		{tx_char_valid_in, tx_char_in, tx_frame_end_in, bit_tick_in} = '0;
		{rx_char_valid_in, rx_char_in, rx_par_bit_in, crc_load_in, crc_value_in} = '0;
		failures = 0;
		cmp_count = 0;
		rstn_in = 1'b0;
		void'($urandom(32'h84925394));
		repeat (6) @(posedge mclk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		// Reset contents of every slot
		for (int i = 0; i < 10; i++)
			rd_chk("reset value", addr_of(map_idx[i]), {24'h0, map_rst[i]}, 1'b0);
		chk_word("coarse at reset", 32'(RST_BAUD[7:5]), 32'(baud_coarse_factor_out));
		// Reserved and read-only slots ignore writes
		foreach (map_idx[i]) begin
			if (i == 2 || i == 3 || i == 5)
				continue;
			wr(addr_of(map_idx[i]), $urandom(), 4'hF);
			rd_chk("write ignored", addr_of(map_idx[i]), {24'h0, map_rst[i]}, 1'b0);
		end
		// Unmapped and unaligned places are refused
		rd_chk("unmapped low", 8'h64, 32'h0, 1'b1);
		rd_chk("unmapped high", 8'h90, 32'h0, 1'b1);
		rd_chk("unaligned", 8'h7D, 32'h0, 1'b1);
		// Baud factors: corners then random values
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
			wr(addr_of(IDX_BAUD), {24'($urandom()), v}, 4'hF);
			rd_chk("baud reg", addr_of(IDX_BAUD), {24'h0, v}, 1'b0);
			chk_word("coarse factor", 32'(v[7:5]), 32'(baud_coarse_factor_out));
			chk_word("fine factor", 32'(v[4:0]), 32'(baud_fine_factor_out));
		end
		// Strobe low leaves the register alone
		wr(addr_of(IDX_BAUD), 32'h0000_0055, 4'hE);
		rd_chk("baud no strobe", addr_of(IDX_BAUD), {24'h0, v}, 1'b0);
		// Response wait: every field value, full count of bit periods
		for (int f = 0; f < 4; f++) begin
			wr(addr_of(IDX_TX_WAIT), {24'h0, 8'($urandom()) & 8'hFC | 8'(f)}, 4'hF);
			rd_chk("wait reg", addr_of(IDX_TX_WAIT), {24'h0, TX_WAIT_FIXED | 8'(f)}, 1'b0);
			chk_word("wait bits", 32'(RESP_WAIT_BASE) + 32'(f), 32'(response_wait_bits_out));
			@(posedge mclk_in);
			tx_frame_end_in <= 1'b1;
			@(posedge mclk_in);
			tx_frame_end_in <= 1'b0;
			for (int t = 1; t <= 7 + f; t++) begin
				@(posedge mclk_in);
				bit_tick_in <= 1'b1;
				@(posedge mclk_in);
				bit_tick_in <= 1'b0;
				#1;
				if (t < 7 + f)
					chk_bit("wait busy", 1'b1, response_wait_busy_out);
				chk_bit("wait done", (t == 7 + f), response_wait_done_out);
			end
			@(posedge mclk_in);
			#1;
			chk_bit("busy after wait", 1'b0, response_wait_busy_out);
		end
		// Restart during a wait, tick in the same cycle: the full wait is reloaded
		@(posedge mclk_in);
		tx_frame_end_in <= 1'b1;
		@(posedge mclk_in);
		bit_tick_in <= 1'b1;
		@(posedge mclk_in);
		{tx_frame_end_in, bit_tick_in} <= 2'b00;
		for (int t = 1; t <= int'(RESP_WAIT_BASE) + 3; t++) begin
			@(posedge mclk_in);
			bit_tick_in <= 1'b1;
			@(posedge mclk_in);
			bit_tick_in <= 1'b0;
			#1;
			chk_bit("restart done", (t == int'(RESP_WAIT_BASE) + 3), response_wait_done_out);
		end
		// Parity generation and checking, then bypass
		for (int m = 0; m < 2; m++) begin
			b = m[0];
			wr(addr_of(IDX_PARITY), {24'h0, 8'($urandom()) & 8'hEF | {3'h0, b, 4'h0}}, 4'hF);
			rd_chk("parity reg", addr_of(IDX_PARITY), {27'h0, b, 4'h0}, 1'b0);
			for (int i = 0; i < 16; i++) begin
				c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
				p = (i < 2) ? ~odd_par(c) : 1'($urandom());
				@(posedge mclk_in);
				{tx_char_valid_in, rx_char_valid_in} <= 2'b11;
				tx_char_in <= c;
				rx_char_in <= c;
				rx_par_bit_in <= p;
				@(posedge mclk_in);
				{tx_char_valid_in, rx_char_valid_in} <= 2'b00;
				#1;
				chk_bit("tx parity valid", ~b, tx_parity_valid_out);
				chk_bit("tx parity", b ? 1'b0 : odd_par(c), tx_parity_out);
				chk_bit("rx data valid", 1'b1, rx_data_valid_out);
				chk_word("rx data", 32'(c), 32'(rx_data_out));
				chk_bit("rx extra valid", b, rx_extra_valid_out);
				if (b)
					chk_bit("rx extra bit", p, rx_extra_bit_out);
				chk_bit("rx parity err", ~b & (p != odd_par(c)), rx_parity_err_out);
			end
		end
		// Checksum result pair, read only once the load has completed
		@(posedge mclk_in);
		crc_load_in <= 1'b1;
		crc_value_in <= 16'($urandom());
		@(posedge mclk_in);
		crc_load_in <= 1'b0;
		rd_chk("checksum high", addr_of(IDX_CRC_HIGH), {24'h0, crc_value_in[15:8]}, 1'b0);
		rd_chk("checksum low", addr_of(IDX_CRC_LOW), {24'h0, crc_value_in[7:0]}, 1'b0);
		wr(addr_of(IDX_CRC_LOW), 32'h0000_00A5, 4'hF);
		rd_chk("checksum read only", addr_of(IDX_CRC_LOW), {24'h0, crc_value_in[7:0]}, 1'b0);
		// Second reset in mid-run brings back the reset contents over written values
		rstn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		rd_chk("baud after reset", addr_of(IDX_BAUD), {24'h0, RST_BAUD}, 1'b0);
		rd_chk("parity after reset", addr_of(IDX_PARITY), {24'h0, RST_PARITY}, 1'b0);
		rd_chk("checksum after reset", addr_of(IDX_CRC_LOW), {24'h0, RST_CRC_BYTE}, 1'b0);
		repeat (4) @(posedge mclk_in);
		stop_test();
	end

endmodule : test_contactless_frame_config_regs
